// file: common/sdbp_cfg_if.sv
// Interface: configuration and status between register file and core
interface sdbp_cfg_if;
  logic       cas_lat3;
  logic [2:0] burst_code;
  logic [1:0] bank_active;
  logic [1:0] bank_prech;
  logic       rd_busy;
  logic       wr_busy;
  modport regs (output cas_lat3, burst_code,
                input  bank_active, bank_prech, rd_busy, wr_busy);
  modport core (input  cas_lat3, burst_code,
                output bank_active, bank_prech, rd_busy, wr_busy);
endinterface

// file: common/sdbp_pkg.sv
// Package: constants, register map and helpers of the SDRAM core
package sdbp_pkg;
  // Clock and widths
  localparam int CLK_MHZ    = 50;
  localparam int ADDR_W     = 12;
  localparam int DQ_W       = 16;
  localparam int COL_W      = 8;
  localparam int ROW_ADDR_W = 11;
  localparam int LANES      = 2;
  localparam int LANE_W     = 8;
  // Address bit positions
  localparam int ROW_BANK_SELECT_BIT    = 11;
  localparam int PRECHARGE_ALL_BIT      = 10;
  localparam int COLUMN_BANK_SELECT_BIT = 11;
  localparam int AUTOPRECHARGE_FLAG_BIT = 10;
  // Commands as {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_BST = 3'h6;
  // Timing
  localparam int T_RP_NS  = 20;
  localparam int T_RP_RAW = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC = (T_RP_RAW < 1) ? 1 : T_RP_RAW;
  localparam int READ_MASK_LAT  = 2;
  localparam int WRITE_MASK_LATENCY = 0;
  localparam logic [1:0] READ_AUTOPRECHARGE_LEAD = 2'h1;
  localparam logic [1:0] WR_AP_DELAY = 2'h2;
  // Burst length codes
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam int FULL_PAGE_LEN = 256;
  // Register map
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CFG_CL3_BIT = 0;
  localparam int CFG_BL_LSB  = 1;
  localparam int CFG_BL_MSB  = 3;
  localparam logic [3:0] CFG_RST = 4'h7;

  // Last burst index for a length code
  function automatic logic [7:0] sdbp_burst_last(input logic [2:0] code);
    case (code)
      3'h0:    return 8'h00;
      3'h1:    return 8'h01;
      3'h2:    return 8'h03;
      3'h3:    return 8'h07;
      3'h7:    return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  // Sequential column step, wrapping inside the burst block
  function automatic logic [7:0] sdbp_next_col(input logic [7:0] col,
                                               input logic [7:0] last);
    return (col & ~last) | ((col + 8'h01) & last);
  endfunction
endpackage

// file: rtl/sdbp_bank.sv
// Bank: idle, active and precharge tracking of one bank
module sdbp_bank import sdbp_pkg::*; #(
  parameter int ROW_W   = ROW_ADDR_W,
  parameter int TRP_CYC = T_RP_CYC
) (
  // System
  input  wire logic             clk,
  input  wire logic             rst,
  // Commands
  input  wire logic             act,
  input  wire logic             pre,
  input  wire logic [ROW_W-1:0] row_in,
  // State
  output logic                  active,
  output logic                  prech,
  output logic      [ROW_W-1:0] row
);
  typedef enum logic [2:0] {
    BK_IDLE   = 3'b001,
    BK_ACTIVE = 3'b010,
    BK_PRECH  = 3'b100
  } sdbp_bank_st_t;

  sdbp_bank_st_t st_r;
  logic [7:0]    cnt_r;
  logic          ready;

  if (TRP_CYC < 1 || TRP_CYC > 255) begin : g_chk
    $error("TRP_CYC out of range");
  end

  assign ready  = (st_r == BK_IDLE) || (st_r == BK_PRECH && cnt_r == 8'h01);
  assign active = (st_r == BK_ACTIVE);
  assign prech  = (st_r == BK_PRECH);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r  <= BK_IDLE;
      cnt_r <= 8'h00;
      row   <= '0;
    end else begin
      case (st_r)
        BK_ACTIVE: begin
          if (pre) begin
            st_r  <= BK_PRECH;
            cnt_r <= 8'(TRP_CYC);
          end
        end
        BK_PRECH, BK_IDLE: begin
          if (act && ready) begin
            st_r <= BK_ACTIVE;
            row  <= row_in;
          end else if (st_r == BK_PRECH) begin
            // Idle after the row precharge time [R21]
            if (cnt_r == 8'h01) st_r <= BK_IDLE;
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: st_r <= BK_IDLE;
      endcase
    end
  end

  property p_pre_start;
    @(posedge clk) disable iff (rst)
      pre && active |=> prech && cnt_r == 8'(TRP_CYC);
  endproperty
  a_pre_start: assert property (p_pre_start) // [R21]
    else $error("precharge did not start timing");

  property p_pre_done;
    @(posedge clk) disable iff (rst)
      prech && cnt_r == 8'h01 && !act |=> st_r == BK_IDLE;
  endproperty
  a_pre_done: assert property (p_pre_done) // [R21]
    else $error("bank not idle after precharge time");
endmodule // sdbp_bank

// file: rtl/sdbp_core.sv
// Top: two-bank SDRAM command decode, burst engines and storage array
// Function
// R01 - Active and precharge take bank from bit 11, row from bits 0-10.
// R02 - Read and write take bank from bit 11; bit 10 requests auto-precharge.
// R03 - Column is bits 0-7; bits 8 and 9 are ignored.
// R04 - Precharge hits the addressed bank, or both banks when bit 10 is high.
// R05 - Read data appears after CAS latency, then one new word each clock.
// R06 - Outputs enable at latency minus one, release after last word.
// R07 - Read byte masks act per lane two clocks after the mask pins.
// R08 - Controller opens a bank before reading or writing it.
// R09 - Write data is captured on the command clock itself.
// R10 - Write burst ends after burst length; full page runs until stopped.
// R11 - Controller waits write recovery before precharging.
// R12 - Write byte masks act per lane in the same clock.
// R13 - Read auto-precharge starts one or two clocks before last word.
// R14 - Controller waits row precharge time before reactivating.
// R15 - Write auto-precharge starts two clocks after last data word.
// R16 - No auto-precharge in full page mode.
// R17 - A new read replaces a running read after CAS latency.
// R18 - A new write replaces a running write from its own command.
// R19 - Controller releases data bus a cycle before read data.
// R20 - Controller masks read output when a write interrupts a read.
// R21 - Precharged bank returns to idle after row precharge time.
// R22 - Precharge stops a read; output continues CAS latency clocks.
// R23 - Full page bursts cover 256 columns and wrap until stopped.
module sdbp_core import sdbp_pkg::*; #(
  parameter int ROW_W   = ROW_ADDR_W,
  parameter int TRP_CYC = T_RP_CYC
) (
  // System
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // Wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // Command pins
  input  wire logic              CS_N,
  input  wire logic              RAS_N,
  input  wire logic              CAS_N,
  input  wire logic              WE_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [LANES-1:0]  BYTE_LANE_MASKS,
  // Data pins
  input  wire logic [DQ_W-1:0]   DQ_I,
  output logic      [DQ_W-1:0]   DQ_O,
  output logic      [LANES-1:0]  DQ_OE
);
  localparam int MEM_AW = 1 + ROW_W + COL_W;
  localparam int BASE_W = 1 + ROW_W;
  localparam int DEPTH  = 1 << MEM_AW;
  localparam int PIN_W  = 4 + ADDR_W + LANES + DQ_W;

  if (ROW_W < 1 || ROW_W > ROW_ADDR_W) begin : g_chk
    $error("ROW_W out of range");
  end
  if (FULL_PAGE_LEN != 256) begin : g_chk_page
    $error("full page must match column width");
  end

  sdbp_cfg_if cfg ();

  sdbp_wb_regs u_regs (
    .clk   (CLK),
    .rst   (SYS_RST),
    .cyc   (WB_CYC_I),
    .stb   (WB_STB_I),
    .we    (WB_WE_I),
    .adr   (WB_ADR_I),
    .sel   (WB_SEL_I),
    .dat_i (WB_DAT_I),
    .dat_o_r (WB_DAT_O),
    .ack_r (WB_ACK_O),
    .cfg   (cfg.regs)
  );

  // Pin synchronisers
  logic [PIN_W-1:0]  pin_m_r;
  logic [PIN_W-1:0]  pin_s_r;
  logic              cs_n_s;
  logic [2:0]        cmd_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0]  dqm_s;
  logic [DQ_W-1:0]   dq_s;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_m_r <= '1;
      pin_s_r <= '1;
    end else begin
      pin_m_r <= {CS_N, RAS_N, CAS_N, WE_N, ADDR, BYTE_LANE_MASKS, DQ_I};
      pin_s_r <= pin_m_r;
    end
  end

  assign {cs_n_s, cmd_s, addr_s, dqm_s, dq_s} = pin_s_r;

  // Command decode
  logic             cmd_act;
  logic             cmd_rd;
  logic             cmd_wr;
  logic             cmd_pre;
  logic             cmd_bst;
  logic             row_bank;
  logic             col_bank;
  logic             pre_all;
  logic [COL_W-1:0] col_s;
  logic             ap_req;
  logic             cl3;
  logic             full_pg;
  logic [7:0]       burst_last;

  assign cmd_act  = !cs_n_s && cmd_s == CMD_ACT;
  assign cmd_rd   = !cs_n_s && cmd_s == CMD_RD;
  assign cmd_wr   = !cs_n_s && cmd_s == CMD_WR;
  assign cmd_pre  = !cs_n_s && cmd_s == CMD_PRE;
  assign cmd_bst  = !cs_n_s && cmd_s == CMD_BST;
  assign row_bank = addr_s[ROW_BANK_SELECT_BIT]; // [R01]
  assign col_bank = addr_s[COLUMN_BANK_SELECT_BIT]; // [R02]
  assign pre_all  = addr_s[PRECHARGE_ALL_BIT]; // [R04]
  assign col_s    = addr_s[COL_W-1:0]; // [R03]
  assign cl3        = cfg.cas_lat3;
  assign full_pg    = cfg.burst_code == BL_CODE_FULL;
  assign burst_last = sdbp_burst_last(cfg.burst_code);
  // Auto-precharge is dropped in full page mode
  assign ap_req = addr_s[AUTOPRECHARGE_FLAG_BIT] && !full_pg; // [R02] [R16]

  // Banks
  logic [1:0]       bank_active;
  logic [1:0]       bank_prech;
  logic [1:0]       pre_hit;
  logic [1:0]       ap_fire;
  logic [1:0]       ap_cnt_r [2];
  logic [ROW_W-1:0] open_row [2];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign ap_fire[b] = ap_cnt_r[b] == 2'h1;
    assign pre_hit[b] = (cmd_pre && (pre_all || row_bank == 1'(b)))
                        || ap_fire[b]; // [R04] [R13] [R15]
    sdbp_bank #(
      .ROW_W   (ROW_W),
      .TRP_CYC (TRP_CYC)
    ) u_bank (
      .clk    (CLK),
      .rst    (SYS_RST),
      .act    (cmd_act && row_bank == 1'(b)),
      .pre    (pre_hit[b]),
      .row_in (addr_s[ROW_W-1:0]), // [R01]
      .active (bank_active[b]),
      .prech  (bank_prech[b]),
      .row    (open_row[b])
    );
  end

  // Read burst engine
  logic [BASE_W-1:0] rd_base_r;
  logic [COL_W-1:0]  rd_col_r;
  logic [7:0]        rd_left_r;
  logic              rd_ap_r;
  logic              rd_stop;
  logic              rd_cont;
  logic              issue_v;
  logic [MEM_AW-1:0] issue_addr;
  logic              rd_bank_now;
  logic              rd_last_ap;

  assign rd_stop = cmd_rd || cmd_wr || cmd_bst || (cmd_pre
                   && (pre_all || row_bank == rd_base_r[BASE_W-1])); // [R22]
  assign rd_cont = rd_left_r != 8'h00 && !rd_stop;
  assign issue_v = cmd_rd || rd_cont;
  // Row comes from the bank the controller opened beforehand [R08]
  assign issue_addr = cmd_rd ? {col_bank, open_row[col_bank], col_s}
                             : {rd_base_r, rd_col_r};
  assign rd_bank_now = cmd_rd ? col_bank : rd_base_r[BASE_W-1];
  assign rd_last_ap  = cmd_rd ? (burst_last == 8'h00 && ap_req)
                       : (rd_cont && rd_left_r == 8'h01 && rd_ap_r
                          && !full_pg);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_base_r <= '0;
      rd_col_r  <= '0;
      rd_left_r <= 8'h00;
      rd_ap_r   <= 1'b0;
    end else if (cmd_rd) begin
      // A new read replaces the running one [R17]
      rd_base_r <= {col_bank, open_row[col_bank]};
      rd_col_r  <= sdbp_next_col(col_s, burst_last); // [R05] [R23]
      rd_left_r <= burst_last;
      rd_ap_r   <= ap_req;
    end else if (rd_stop) begin
      rd_left_r <= 8'h00;
    end else if (rd_cont) begin
      rd_col_r <= sdbp_next_col(rd_col_r, burst_last); // [R05] [R23]
      if (!full_pg) rd_left_r <= rd_left_r - 8'h01;
    end
  end

  // Write burst engine
  logic [BASE_W-1:0] wr_base_r;
  logic [COL_W-1:0]  wr_col_r;
  logic [7:0]        wr_left_r;
  logic              wr_ap_r;
  logic              wr_stop;
  logic              wr_cont;
  logic              mem_we;
  logic [LANES-1:0]  mem_be;
  logic [MEM_AW-1:0] mem_waddr;
  logic              wr_bank_now;
  logic              wr_last_ap;

  assign wr_stop = cmd_rd || cmd_wr || cmd_bst || (cmd_pre
                   && (pre_all || row_bank == wr_base_r[BASE_W-1]));
  assign wr_cont = wr_left_r != 8'h00 && !wr_stop;
  assign mem_we  = cmd_wr || wr_cont; // [R09]
  assign mem_be  = ~dqm_s; // [R12]
  assign mem_waddr = cmd_wr ? {col_bank, open_row[col_bank], col_s}
                            : {wr_base_r, wr_col_r};
  assign wr_bank_now = cmd_wr ? col_bank : wr_base_r[BASE_W-1];
  assign wr_last_ap  = cmd_wr ? (burst_last == 8'h00 && ap_req)
                       : (wr_cont && wr_left_r == 8'h01 && wr_ap_r
                          && !full_pg);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_base_r <= '0;
      wr_col_r  <= '0;
      wr_left_r <= 8'h00;
      wr_ap_r   <= 1'b0;
    end else if (cmd_wr) begin
      // A new write takes over from its own command [R18]
      wr_base_r <= {col_bank, open_row[col_bank]};
      wr_col_r  <= sdbp_next_col(col_s, burst_last);
      wr_left_r <= burst_last; // [R10]
      wr_ap_r   <= ap_req;
    end else if (wr_stop) begin
      wr_left_r <= 8'h00;
    end else if (wr_cont) begin
      wr_col_r <= sdbp_next_col(wr_col_r, burst_last); // [R23]
      if (!full_pg) wr_left_r <= wr_left_r - 8'h01; // [R10]
    end
  end

  // Auto-precharge launch per bank
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ap_cnt_r[0] <= 2'h0;
      ap_cnt_r[1] <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (rd_last_ap && rd_bank_now == 1'(b))
          ap_cnt_r[b] <= READ_AUTOPRECHARGE_LEAD; // [R13]
        else if (wr_last_ap && wr_bank_now == 1'(b))
          ap_cnt_r[b] <= WR_AP_DELAY; // [R15]
        else if (ap_cnt_r[b] != 2'h0)
          ap_cnt_r[b] <= ap_cnt_r[b] - 2'h1;
      end
    end
  end

  // Storage array with per-lane write enables
  logic [DQ_W-1:0] mem [DEPTH];

  always_ff @(posedge CLK) begin
    if (mem_we) begin
      for (int l = 0; l < LANES; l++) begin
        if (mem_be[l]) // [R12]
          mem[mem_waddr][l*LANE_W +: LANE_W] <= dq_s[l*LANE_W +: LANE_W];
      end
    end
  end

  // Read pipeline and output stage
  logic [1:0]       pipe_v_r;
  logic [DQ_W-1:0]  pipe_d0_r;
  logic [DQ_W-1:0]  pipe_d1_r;
  logic             tap_v;
  logic [DQ_W-1:0]  tap_d;
  logic             lead_v;
  logic             out_v_r;
  logic             oe_any_r;
  logic [LANES-1:0] dqm_d_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pipe_v_r  <= 2'h0;
      pipe_d0_r <= '0;
      pipe_d1_r <= '0;
    end else begin
      pipe_v_r  <= {pipe_v_r[0], issue_v};
      pipe_d0_r <= mem[issue_addr];
      pipe_d1_r <= pipe_d0_r;
    end
  end

  // Tap chosen by CAS latency; the lead tap opens the drivers early
  assign tap_v  = cl3 ? pipe_v_r[1] : pipe_v_r[0]; // [R05] [R22]
  assign tap_d  = cl3 ? pipe_d1_r : pipe_d0_r;
  assign lead_v = cl3 ? pipe_v_r[0] : issue_v; // [R06]

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_v_r  <= 1'b0;
      DQ_O     <= '0;
      oe_any_r <= 1'b0;
      dqm_d_r  <= '0;
      DQ_OE    <= '0;
    end else begin
      out_v_r  <= tap_v;
      DQ_O     <= tap_v ? tap_d : '0; // [R05]
      oe_any_r <= tap_v || lead_v; // [R06]
      dqm_d_r  <= dqm_s; // [R07]
      DQ_OE    <= {LANES{tap_v || lead_v}} & ~dqm_d_r; // [R06] [R07]
    end
  end

  // Status towards the register file
  assign cfg.bank_active = bank_active;
  assign cfg.bank_prech  = bank_prech;
  assign cfg.rd_busy     = rd_left_r != 8'h00 || out_v_r;
  assign cfg.wr_busy     = wr_left_r != 8'h00;

  // Checks
  sequence s_rd_cl2;
    cmd_rd && !cl3;
  endsequence
  sequence s_rd_cl3;
    cmd_rd && cl3;
  endsequence
  sequence s_wr4;
    cmd_wr && burst_last == 8'h03 ##1 !wr_stop [*3];
  endsequence

  property p_rd_cl2;
    @(posedge CLK) disable iff (SYS_RST) s_rd_cl2 |-> ##2 out_v_r;
  endproperty
  a_rd_cl2: assert property (p_rd_cl2) // [R05]
    else $error("read data late at latency 2");

  property p_rd_cl3;
    @(posedge CLK) disable iff (SYS_RST)
      s_rd_cl3 |-> ##3 out_v_r;
  endproperty
  a_rd_cl3: assert property (p_rd_cl3) // [R05]
    else $error("read data late at latency 3");

  property p_oe_lead;
    @(posedge CLK) disable iff (SYS_RST) $rose(out_v_r) |-> $past(oe_any_r);
  endproperty
  a_oe_lead: assert property (p_oe_lead) // [R06]
    else $error("drivers not on one cycle before data");

  property p_rd_mask;
    @(posedge CLK) disable iff (SYS_RST)
      oe_any_r |-> DQ_OE == ~$past(dqm_s, 2);
  endproperty
  a_rd_mask: assert property (p_rd_mask) // [R07]
    else $error("read mask not two clocks");

  property p_wr_zero;
    @(posedge CLK) disable iff (SYS_RST)
      cmd_wr |-> mem_we && mem_be == ~dqm_s
                 && mem_waddr[COL_W-1:0] == col_s;
  endproperty
  a_wr_zero: assert property (p_wr_zero) // [R09] [R12]
    else $error("write data not taken on command clock");

  property p_wr_len4;
    @(posedge CLK) disable iff (SYS_RST) s_wr4 |=> wr_left_r == 8'h00;
  endproperty
  a_wr_len4: assert property (p_wr_len4) // [R10]
    else $error("write burst of four did not end");

  property p_rd_ap;
    @(posedge CLK) disable iff (SYS_RST) rd_last_ap |=> pre_hit != 2'h0;
  endproperty
  a_rd_ap: assert property (p_rd_ap) // [R13]
    else $error("read auto-precharge not started");

  property p_wr_ap;
    @(posedge CLK) disable iff (SYS_RST)
      wr_last_ap |-> ##1 ap_fire == 2'h0 ##1 ap_fire != 2'h0;
  endproperty
  a_wr_ap: assert property (p_wr_ap) // [R15]
    else $error("write auto-precharge not two clocks after data");

  property p_full_no_ap;
    @(posedge CLK) disable iff (SYS_RST)
      (cmd_rd || cmd_wr) && full_pg |=> !rd_ap_r && !wr_ap_r;
  endproperty
  a_full_no_ap: assert property (p_full_no_ap) // [R16]
    else $error("auto-precharge armed in full page");

  property p_pre_stop;
    @(posedge CLK) disable iff (SYS_RST)
      cmd_pre && rd_left_r != 8'h00 && !cmd_rd
      && (pre_all || row_bank == rd_base_r[BASE_W-1]) |=> !issue_v;
  endproperty
  a_pre_stop: assert property (p_pre_stop) // [R22]
    else $error("precharge did not stop read");

  property p_rd_restart;
    @(posedge CLK) disable iff (SYS_RST)
      cmd_rd && !full_pg |=> rd_left_r == $past(burst_last);
  endproperty
  a_rd_restart: assert property (p_rd_restart) // [R17]
    else $error("new read did not restart burst");
endmodule // sdbp_core

// file: rtl/sdbp_wb_regs.sv
// Registers: Wishbone slave for configuration and status
module sdbp_wb_regs import sdbp_pkg::*; (
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [7:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o_r,
  output logic             ack_r,
  // Core side
  sdbp_cfg_if.regs         cfg
);
  logic [3:0] cfg_r;
  logic       req;

  assign req            = cyc && stb && !ack_r;
  assign cfg.cas_lat3   = cfg_r[CFG_CL3_BIT];
  assign cfg.burst_code = cfg_r[CFG_BL_MSB:CFG_BL_LSB];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ack_r <= 1'b0;
    else     ack_r <= req;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfg_r <= CFG_RST;
    else if (req && we && adr == REG_CFG && sel[0]) cfg_r <= dat_i[3:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) dat_o_r <= 32'h0000_0000;
    else if (req) begin
      case (adr)
        REG_CFG:  dat_o_r <= {28'h000_0000, cfg_r};
        REG_STAT: dat_o_r <= {26'h000_0000, cfg.wr_busy, cfg.rd_busy,
                              cfg.bank_prech, cfg.bank_active};
        default:  dat_o_r <= 32'h0000_0000;
      endcase
    end
  end

  property p_ack_once;
    @(posedge clk) disable iff (rst) ack_r |=> !ack_r;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held for more than one cycle");
endmodule // sdbp_wb_regs

// file: sim/sdbp_ctl_model.sv
// Controller model driving command, mask and write-data pins
module sdbp_ctl_model (
  // Clock
  input  wire logic clk,
  // Pins
  output logic        cs_n,
  output logic [2:0]  cmd,
  output logic [11:0] addr,
  output logic [1:0]  masks,
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    cmd = 3'h7;
    addr = 12'h000;
    masks = 2'h0;
    dq = 16'h0000;
  end
  // Command with its write word on the same edge
  task automatic step(input logic [2:0] c, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
    @(posedge clk);
    cs_n  <= 1'b0;
    cmd   <= c;
    addr  <= a;
    masks <= m;
    dq    <= d;
  endtask
  // Deselect; released data lines show a changing pattern
  task automatic rel(input logic [1:0] m);
    @(posedge clk);
    cs_n  <= 1'b1;
    masks <= m;
    dq    <= ~dq;
  endtask
endmodule // sdbp_ctl_model

// file: sim/tb.sv
// Testbench: registers, burst write and read, masks, precharge
module tb import sdbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst, cyc, stb, we, ack, cs_n;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  cmd;
  logic [11:0] addr;
  logic [1:0]  msk, oe;
  logic [15:0] dqi, dqo;
  logic [15:0] w [4];
  int          n_fail = 0, checks_done = 0, seed = 93, cyc_cnt = 0;

  sdbp_core #(.TRP_CYC(2)) u_dut (
    .CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .CS_N(cs_n), .RAS_N(cmd[2]),
    .CAS_N(cmd[1]), .WE_N(cmd[0]), .ADDR(addr), .BYTE_LANE_MASKS(msk),
    .DQ_I(dqi), .DQ_O(dqo), .DQ_OE(oe));
  sdbp_ctl_model u_ctl (.clk(clk), .cs_n(cs_n), .cmd(cmd), .addr(addr),
    .masks(msk), .dq(dqi));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w_en, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w_en;
    sel  <= s;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin : main
    logic [7:0]  c;
    logic [15:0] v, mk;
    rst  = 1'b1;
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    sel  = 4'hF;
    adr  = 8'h00;
    wdat = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({30'h0, oe}, 32'h0);
    wb(1'b0, REG_CFG, 32'h0);
    chk(q, 32'h7);
    wb(1'b1, REG_CFG, 32'h0, 4'hE);
    wb(1'b0, REG_CFG, 32'h0);
    chk(q, 32'h7);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    for (int cl = 2; cl <= 3; cl++) begin
      wb(1'b1, REG_CFG, {28'h0, 3'h2, cl == 3});
      c = 8'($random(seed));
      u_ctl.step(CMD_ACT, 12'h0A5, 2'h0, 16'h0);
      u_ctl.step(CMD_ACT, 12'h85A, 2'h0, 16'h0);
      u_ctl.rel(2'h0);
      for (int i = 0; i < 4; i++) w[i] = 16'($random(seed));
      for (int i = 0; i < 4; i++)
        u_ctl.step(i ? 3'h7 : CMD_WR, {4'h0, c}, 2'h0, w[i]);
      u_ctl.rel(2'h0);
      for (int i = 0; i < 4; i++) begin
        v = 16'($random(seed));
        u_ctl.step(i ? 3'h7 : CMD_WR, {4'h0, c}, 2'h1, v);
        w[i][15:8] = v[15:8];
      end
      u_ctl.rel(2'h0);
      u_ctl.step(CMD_RD, {4'h3, c[7:2], c[1:0] + 2'h1}, 2'h0, 16'h0);
      for (int k = 1; k <= cl + 6; k++) begin
        u_ctl.rel(k == cl ? 2'h2 : 2'h0);
        #1;
        if (k == cl + 1) chk({30'h0, oe}, 32'h3);
        if (k == cl + 4) chk({30'h0, oe}, 32'h1);
        if (k == cl + 6) chk({30'h0, oe}, 32'h0);
        mk = k == cl + 4 ? 16'h00FF : 16'hFFFF;
        if (k >= cl + 2 && k < cl + 6)
          chk(dqo & mk, w[(k - cl - 1) & 3] & mk);
      end
      u_ctl.step(CMD_RD, {4'h0, c}, 2'h0, 16'h0);
      u_ctl.rel(2'h0);
      u_ctl.step(CMD_PRE, 12'h000, 2'h0, 16'h0);
      for (int k = 3; k <= cl + 4; k++) begin
        u_ctl.rel(2'h0);
        #1;
        if (k == cl + 3) chk({30'h0, oe}, 32'h3);
        if (k == cl + 4) chk({30'h0, oe}, 32'h0);
      end
      wb(1'b0, REG_STAT, 32'h0);
      chk({30'h0, q[1:0]}, 32'h2);
      u_ctl.step(CMD_RD, {4'hC, c}, 2'h0, 16'h0);
      repeat (10) u_ctl.rel(2'h0);
      wb(1'b0, REG_STAT, 32'h0);
      chk({26'h0, q[5:0]}, 32'h0);
      u_ctl.step(CMD_ACT, 12'h85A, 2'h0, 16'h0);
      for (int i = 0; i < 4; i++)
        u_ctl.step(i ? 3'h7 : CMD_WR, {4'hC, c}, 2'h0, w[i]);
      repeat (10) u_ctl.rel(2'h0);
      wb(1'b0, REG_STAT, 32'h0, 4'h1);
      chk({26'h0, q[5:0]}, 32'h0);
      u_ctl.step(CMD_PRE, 12'h400, 2'h0, 16'h0);
      repeat (8) u_ctl.rel(2'h0);
      wb(1'b0, REG_STAT, 32'h0);
      chk({26'h0, q[5:0]}, 32'h0);
      $display("test latency %0d done", cl);
    end
    test_done();
  end
endmodule // tb
